// file: ucfl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module ucfl_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic hreadyout, hresp, nvm_save_stb, motor_overload_fault;
  logic [31:0] hrdata;
  logic drive_enabled = 1'b0, fan_on = 1'b0, dc_undervoltage = 1'b0;
  // strobes held for n sampling edges by hold: overload up, down, encoder, wh, nvm load
  logic [4:0] stb_q = 5'h00;
  localparam int S_UP = 0;
  localparam int S_DN = 1;
  localparam int S_ENC = 2;
  localparam int S_WH = 3;
  localparam int S_LD = 4;
  logic enc_dir_cw = 1'b0, fault_active = 1'b0;
  logic [15:0] ao_b_other = 16'h4321;
  logic [15:0] enc_speed_raw = 16'h0, ao_a_value, ao_b_value;
  logic [9:0] alarm_code_in = 10'h0, fault_code_in = 10'h0;
  ucfl_pkg::ucfl_rtc_t rtc_now = '0;
  logic [7:0] digital_inputs = 8'h0;
  ucfl_pkg::ucfl_nvm_t nvm_load_data = '0, nvm_save_data;
  int n_fail = 0;
  int checked = 0;

  // ------------------------------------------------------------
  // clock and design
  // ------------------------------------------------------------
  always #25 clk_sys = ~clk_sys;

  ucfl_top #(.CYC_PER_SEC(10), .FILT_STEP(2)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .drive_enabled(drive_enabled), .fan_on(fan_on), .dc_undervoltage(dc_undervoltage),
    .overload_up(stb_q[S_UP]), .overload_down(stb_q[S_DN]),
    .energy_wh_pulse(stb_q[S_WH]), .enc_pulse(stb_q[S_ENC]), .enc_dir_cw(enc_dir_cw),
    .enc_speed_raw(enc_speed_raw), .alarm_code_in(alarm_code_in),
    .fault_active(fault_active), .fault_code_in(fault_code_in), .rtc_now(rtc_now),
    .digital_inputs(digital_inputs), .nvm_load(stb_q[S_LD]), .nvm_load_data(nvm_load_data),
    .nvm_save_stb(nvm_save_stb), .nvm_save_data(nvm_save_data),
    .ao_a_other(16'h1234), .ao_b_other(ao_b_other), .ao_a_value(ao_a_value),
    .ao_b_value(ao_b_value), .motor_overload_fault(motor_overload_fault)
  );

  // ------------------------------------------------------------
  // bus and stimulus helpers
  // ------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    `CHK(nm, ex, d)
  endtask : rchk

  // holds a strobe high for n sampling edges
  task automatic hold(input int b, input int n);
    @(posedge clk_sys);
    stb_q[b] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    stb_q[b] <= 1'b0;
  endtask : hold

  task automatic nload(input logic [15:0] p, e, k, f);
    @(posedge clk_sys);
    nvm_load_data <= '{powered: p, enabled: e, energy: k, fan: f};
    hold(S_LD, 1);
  endtask : nload

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_bus;
    rchk("unmapped", 12'h3fc, 32'h0);
    wr(ucfl_pkg::ADDR_OVERLOAD, 32'h55);
    rchk("ro overload", ucfl_pkg::ADDR_OVERLOAD, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    $display("test bus done");
  endtask : t_bus

  task automatic t_overload;
    hold(S_UP, 101);
    repeat (2) @(posedge clk_sys);
    rchk("overload max", ucfl_pkg::ADDR_OVERLOAD, 32'd100);
    `CHK("overload fault", 1'b1, motor_overload_fault)
    hold(S_DN, 1);
    repeat (2) @(posedge clk_sys);
    `CHK("overload fault off", 1'b0, motor_overload_fault)
    rchk("overload 99", ucfl_pkg::ADDR_OVERLOAD, 32'd99);
    $display("test overload done");
  endtask : t_overload

  task automatic t_encoder;
    hold(S_ENC, 2);
    rchk("pulses floor", ucfl_pkg::ADDR_PULSES, 32'd0);
    enc_dir_cw <= 1'b1;
    hold(S_ENC, 5);
    enc_dir_cw <= 1'b0;
    hold(S_ENC, 2);
    rchk("pulses net", ucfl_pkg::ADDR_PULSES, 32'd3);
    wr(ucfl_pkg::ADDR_AO_A_SRC, 32'd49);
    wr(ucfl_pkg::ADDR_AO_B_SRC, 32'd49);
    repeat (3) @(posedge clk_sys);
    `CHK("ao a pulses", 16'd3, ao_a_value)
    `CHK("ao b pulses", 16'd3, ao_b_value)
    wr(ucfl_pkg::ADDR_AO_A_SRC, 32'd48);
    wr(ucfl_pkg::ADDR_AO_B_SRC, 32'd48);
    // even count keeps the filter step phase of the lag read
    repeat (4) @(posedge clk_sys);
    `CHK("ao a other", 16'h1234, ao_a_value)
    `CHK("ao b other", 16'h4321, ao_b_value)
    enc_speed_raw <= 16'd1600;
    rchk("speed lags", ucfl_pkg::ADDR_SPEED, 32'd0);
    repeat (3000) @(posedge clk_sys);
    rchk("speed settled", ucfl_pkg::ADDR_SPEED, 32'd1600);
    $display("test encoder done");
  endtask : t_encoder

  task automatic t_counters;
    logic [2:0] sel [3] = '{3'h2, 3'h3, 3'h4};
    nload(16'h0, 16'hffff, 16'hffff, 16'hffff);
    hold(S_WH, 1000);
    rchk("energy wrap", ucfl_pkg::ADDR_ENERGY, 32'd0);
    hold(S_WH, 1000);
    rchk("energy one", ucfl_pkg::ADDR_ENERGY, 32'd1);
    drive_enabled <= 1'b1;
    fan_on <= 1'b1;
    repeat (3605) @(posedge clk_sys);
    drive_enabled <= 1'b0;
    rchk("enabled wrap", ucfl_pkg::ADDR_ENABLED, 32'd0);
    repeat (32400) @(posedge clk_sys);
    fan_on <= 1'b0;
    rchk("fan wrap", ucfl_pkg::ADDR_FAN, 32'd0);
    rchk("powered hour", ucfl_pkg::ADDR_POWERED, 32'd1);
    foreach (sel[i])
    begin
      nload(16'h20, 16'h20, 16'h20, 16'h20);
      wr(ucfl_pkg::ADDR_RST_SEL, {29'h0, sel[i]});
      rchk("fan clr", ucfl_pkg::ADDR_FAN, (i == 0) ? 32'h0 : 32'h20);
      rchk("enabled clr", ucfl_pkg::ADDR_ENABLED, (i == 1) ? 32'h0 : 32'h20);
      rchk("energy clr", ucfl_pkg::ADDR_ENERGY, (i == 2) ? 32'h0 : 32'h20);
    end
    rchk("powered", ucfl_pkg::ADDR_POWERED, 32'h20);
    $display("test counters done");
  endtask : t_counters

  task automatic t_save;
    int n;
    nload(16'h5, 16'h7, 16'h9, 16'hb);
    @(posedge clk_sys);
    dc_undervoltage <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (nvm_save_stb !== 1'b1 && n < 4);
    `CHK("save strobe", 1'b1, nvm_save_stb)
    `CHK("save powered", 16'h5, nvm_save_data.powered)
    `CHK("save enabled", 16'h7, nvm_save_data.enabled)
    `CHK("save energy", 16'h9, nvm_save_data.energy)
    `CHK("save fan", 16'hb, nvm_save_data.fan)
    dc_undervoltage <= 1'b0;
    $display("test save done");
  endtask : t_save

  task automatic t_faults;
    int j;
    alarm_code_in <= 10'd999;
    rchk("alarm", ucfl_pkg::ADDR_ALARM, 32'd999);
    for (int i = 0; i <= 10; i++)
    begin
      @(posedge clk_sys);
      fault_active <= 1'b1;
      fault_code_in <= 10'(100 + i);
      rtc_now <= '{day: 5'(i + 1), month: 4'(i + 1), year: 7'(i + 20),
                   hour: 5'(i), minute: 6'(i + 30)};
      digital_inputs <= 8'h5a ^ 8'(i);
      rchk("active fault", ucfl_pkg::ADDR_FAULT, 32'(100 + i));
      fault_active <= 1'b0;
      rtc_now <= '0;
    end
    rchk("no fault", ucfl_pkg::ADDR_FAULT, 32'd0);
    rchk("snapshot", ucfl_pkg::ADDR_DI_SNAP, 32'h50);
    for (j = 0; j < 10; j++)
    begin
      rchk("hist code", 12'(ucfl_pkg::ADDR_HIST_CODE + 4 * j), 32'(110 - j));
      rchk("hist dm", 12'(ucfl_pkg::ADDR_HIST_DM + 4 * j),
           32'(((11 - j) << 8) | (11 - j)));
      rchk("hist year", 12'(ucfl_pkg::ADDR_HIST_YEAR + 4 * j), 32'(30 - j));
      rchk("hist time", 12'(ucfl_pkg::ADDR_HIST_TIME + 4 * j),
           32'(((10 - j) << 8) | (40 - j)));
    end
    $display("test faults done");
  endtask : t_faults

  // ------------------------------------------------------------
  // verdict, watchdog, main sequence
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_bus();
    t_overload();
    t_encoder();
    t_counters();
    t_save();
    t_faults();
    give_verdict();
  end
endmodule : ucfl_bench
`default_nettype wire

// file: ucfl_pkg.sv
package ucfl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_OVERLOAD = 12'h000;
  localparam logic [11:0] ADDR_SPEED = 12'h004;
  localparam logic [11:0] ADDR_PULSES = 12'h008;
  localparam logic [11:0] ADDR_POWERED = 12'h00c;
  localparam logic [11:0] ADDR_ENABLED = 12'h010;
  localparam logic [11:0] ADDR_ENERGY = 12'h014;
  localparam logic [11:0] ADDR_FAN = 12'h018;
  localparam logic [11:0] ADDR_ALARM = 12'h01c;
  localparam logic [11:0] ADDR_FAULT = 12'h020;
  localparam logic [11:0] ADDR_RST_SEL = 12'h024;
  localparam logic [11:0] ADDR_AO_A_SRC = 12'h028;
  localparam logic [11:0] ADDR_AO_B_SRC = 12'h02c;
  localparam logic [11:0] ADDR_DI_SNAP = 12'h030;
  localparam logic [11:0] ADDR_HIST_CODE = 12'h040;
  localparam logic [11:0] ADDR_HIST_DM = 12'h080;
  localparam logic [11:0] ADDR_HIST_YEAR = 12'h0c0;
  localparam logic [11:0] ADDR_HIST_TIME = 12'h100;

  // ----------------------------------------------------------------
  // values, limits and timing
  // ----------------------------------------------------------------
  localparam int HIST_DEPTH = 10;
  localparam logic [6:0] OVL_FULL = 7'h64;
  localparam logic [15:0] PULSE_MAX = 16'h9c40;
  localparam logic [7:0] AO_SRC_PULSES = 8'h31;
  localparam logic [2:0] RST_SEL_FAN = 3'h2;
  localparam logic [2:0] RST_SEL_ENABLED = 3'h3;
  localparam logic [2:0] RST_SEL_ENERGY = 3'h4;
  localparam int CLK_HZ = 20_000_000;
  localparam int FILT_TAU_MS = 500;
  localparam int FILT_SHIFT = 4;
  localparam logic [8:0] SEC_PER_TENTH = 9'h168;
  localparam logic [11:0] SEC_PER_HOUR = 12'he10;
  localparam logic [3:0] TENTHS_PER_HOUR = 4'ha;
  localparam logic [9:0] WH_PER_KWH = 10'h3e8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] day;
    logic [3:0] month;
    logic [6:0] year;
    logic [4:0] hour;
    logic [5:0] minute;
  } ucfl_rtc_t;

  typedef struct packed {
    logic [9:0] code;
    ucfl_rtc_t stamp;
  } ucfl_entry_t;

  typedef struct packed {
    logic [15:0] powered;
    logic [15:0] enabled;
    logic [15:0] energy;
    logic [15:0] fan;
  } ucfl_nvm_t;

  typedef enum logic [2:0] {
    DP_IDLE = 3'b001,
    DP_READ = 3'b010,
    DP_WRITE = 3'b100
  } ucfl_dp_t;

endpackage : ucfl_pkg

// file: ucfl_top.sv
`timescale 1ns/10ps
`default_nettype none
module ucfl_top #(
  parameter int CYC_PER_SEC = ucfl_pkg::CLK_HZ,
  parameter int FILT_STEP = ucfl_pkg::CLK_HZ / 1000 * ucfl_pkg::FILT_TAU_MS
                            / (1 << ucfl_pkg::FILT_SHIFT)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // drive status
  input wire logic drive_enabled,
  input wire logic fan_on,
  input wire logic dc_undervoltage,
  input wire logic overload_up,
  input wire logic overload_down,
  input wire logic energy_wh_pulse,
  // encoder
  input wire logic enc_pulse,
  input wire logic enc_dir_cw,
  input wire logic [15:0] enc_speed_raw,
  // alarms, faults, time stamp, inputs
  input wire logic [9:0] alarm_code_in,
  input wire logic fault_active,
  input wire logic [9:0] fault_code_in,
  input wire ucfl_pkg::ucfl_rtc_t rtc_now,
  input wire logic [7:0] digital_inputs,
  // non-volatile store
  input wire logic nvm_load,
  input wire ucfl_pkg::ucfl_nvm_t nvm_load_data,
  output logic nvm_save_stb,
  output ucfl_pkg::ucfl_nvm_t nvm_save_data,
  // analog output sources
  input wire logic [15:0] ao_a_other,
  input wire logic [15:0] ao_b_other,
  output logic [15:0] ao_a_value,
  output logic [15:0] ao_b_value,
  // fault status
  output logic motor_overload_fault
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] overload;
    logic ovl_fault;
    logic [15:0] pulses;
    logic [19:0] filt_acc;
    logic [19:0] filt_cnt;
    logic [24:0] sec_cnt;
    logic [8:0] pw_sec;
    logic [3:0] pw_tenth;
    logic [15:0] powered;
    logic [8:0] en_sec;
    logic [15:0] enabled;
    logic [11:0] fan_sec;
    logic [15:0] fan;
    logic [9:0] wh_cnt;
    logic [15:0] energy;
    logic [9:0] alarm;
    logic [9:0] fault;
    logic fault_prev;
    ucfl_pkg::ucfl_entry_t [ucfl_pkg::HIST_DEPTH-1:0] hist;
    logic [7:0] di_snap;
    logic [7:0] ao_a_src;
    logic [7:0] ao_b_src;
    logic [15:0] ao_a;
    logic [15:0] ao_b;
    logic uv_prev;
    logic nvm_stb;
    ucfl_pkg::ucfl_nvm_t nvm;
    ucfl_pkg::ucfl_dp_t dp;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
  } ucfl_state_t;

  ucfl_state_t s;
  ucfl_state_t next_s;

  logic sec_tick;
  logic filt_tick;
  logic addr_take;
  logic [2:0] rst_sel;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[11:0])
      ucfl_pkg::ADDR_OVERLOAD: rd_mux = {25'h0, s.overload};
      ucfl_pkg::ADDR_SPEED: rd_mux = {16'h0, s.filt_acc[19:4]};
      ucfl_pkg::ADDR_PULSES: rd_mux = {16'h0, s.pulses};
      ucfl_pkg::ADDR_POWERED: rd_mux = {16'h0, s.powered};
      ucfl_pkg::ADDR_ENABLED: rd_mux = {16'h0, s.enabled};
      ucfl_pkg::ADDR_ENERGY: rd_mux = {16'h0, s.energy};
      ucfl_pkg::ADDR_FAN: rd_mux = {16'h0, s.fan};
      ucfl_pkg::ADDR_ALARM: rd_mux = {22'h0, s.alarm};
      ucfl_pkg::ADDR_FAULT: rd_mux = {22'h0, s.fault};
      ucfl_pkg::ADDR_AO_A_SRC: rd_mux = {24'h0, s.ao_a_src};
      ucfl_pkg::ADDR_AO_B_SRC: rd_mux = {24'h0, s.ao_b_src};
      ucfl_pkg::ADDR_DI_SNAP: rd_mux = {24'h0, s.di_snap};
      default: rd_mux = 32'h0000_0000;
    endcase
    for (int i = 0; i < ucfl_pkg::HIST_DEPTH; i++)
    begin
      if (haddr[11:0] == ucfl_pkg::ADDR_HIST_CODE + 12'(4 * i))
        rd_mux = {22'h0, s.hist[i].code};
      if (haddr[11:0] == ucfl_pkg::ADDR_HIST_DM + 12'(4 * i))
        rd_mux = {19'h0, s.hist[i].stamp.day, 4'h0, s.hist[i].stamp.month};
      if (haddr[11:0] == ucfl_pkg::ADDR_HIST_YEAR + 12'(4 * i))
        rd_mux = {25'h0, s.hist[i].stamp.year};
      if (haddr[11:0] == ucfl_pkg::ADDR_HIST_TIME + 12'(4 * i))
        rd_mux = {19'h0, s.hist[i].stamp.hour, 2'h0, s.hist[i].stamp.minute};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign addr_take = hsel & htrans[1] & hready;
  assign sec_tick = (s.sec_cnt == 25'(CYC_PER_SEC - 1));
  assign filt_tick = (s.filt_cnt == 20'(FILT_STEP - 1));
  assign rst_sel = (s.dp == ucfl_pkg::DP_WRITE && s.dp_addr == ucfl_pkg::ADDR_RST_SEL
                    && hwdata[31:3] == 29'h0) ? hwdata[2:0] : 3'h0;

  always_comb
  begin
    next_s = s;
    next_s.nvm_stb = 1'b0;

    // bus data phase and next address phase
    if (s.dp == ucfl_pkg::DP_WRITE)
    begin
      case (s.dp_addr)
        ucfl_pkg::ADDR_AO_A_SRC: next_s.ao_a_src = hwdata[7:0];
        ucfl_pkg::ADDR_AO_B_SRC: next_s.ao_b_src = hwdata[7:0];
        default: next_s.ao_a_src = s.ao_a_src;
      endcase
    end
    next_s.dp = ucfl_pkg::DP_IDLE;
    if (addr_take)
    begin
      next_s.dp = hwrite ? ucfl_pkg::DP_WRITE : ucfl_pkg::DP_READ;
      next_s.dp_addr = haddr[11:0];
      next_s.rdata = hwrite ? 32'h0000_0000 : rd_mux;
    end

    // overload level
    if (overload_up && !overload_down && s.overload != ucfl_pkg::OVL_FULL)
      next_s.overload = s.overload + 7'h01;
    else if (overload_down && !overload_up && s.overload != 7'h00)
      next_s.overload = s.overload - 7'h01;
    next_s.ovl_fault = (next_s.overload == ucfl_pkg::OVL_FULL);

    // encoder pulses, saturating at both ends
    if (enc_pulse && enc_dir_cw && s.pulses != ucfl_pkg::PULSE_MAX)
      next_s.pulses = s.pulses + 16'h0001;
    else if (enc_pulse && !enc_dir_cw && s.pulses != 16'h0000)
      next_s.pulses = s.pulses - 16'h0001;

    // first-order speed filter
    next_s.filt_cnt = filt_tick ? 20'h0 : s.filt_cnt + 20'h1;
    if (filt_tick)
      next_s.filt_acc = 20'({1'b0, s.filt_acc} + {5'h0, enc_speed_raw}
                            - {5'h0, s.filt_acc[19:4]});

    // analog output routing
    next_s.ao_a = (s.ao_a_src == ucfl_pkg::AO_SRC_PULSES) ? s.pulses : ao_a_other;
    next_s.ao_b = (s.ao_b_src == ucfl_pkg::AO_SRC_PULSES) ? s.pulses : ao_b_other;

    // one-second time base
    next_s.sec_cnt = sec_tick ? 25'h0 : s.sec_cnt + 25'h1;
    if (sec_tick)
    begin
      next_s.pw_sec = s.pw_sec + 9'h1;
      if (s.pw_sec == ucfl_pkg::SEC_PER_TENTH - 9'h1)
      begin
        next_s.pw_sec = 9'h0;
        next_s.pw_tenth = s.pw_tenth + 4'h1;
        if (s.pw_tenth == ucfl_pkg::TENTHS_PER_HOUR - 4'h1)
        begin
          next_s.pw_tenth = 4'h0;
          if (s.powered != 16'hffff)
            next_s.powered = s.powered + 16'h1;
        end
      end
      if (drive_enabled)
      begin
        next_s.en_sec = s.en_sec + 9'h1;
        if (s.en_sec == ucfl_pkg::SEC_PER_TENTH - 9'h1)
        begin
          next_s.en_sec = 9'h0;
          next_s.enabled = s.enabled + 16'h1;
        end
      end
      if (fan_on)
      begin
        next_s.fan_sec = s.fan_sec + 12'h1;
        if (s.fan_sec == ucfl_pkg::SEC_PER_HOUR - 12'h1)
        begin
          next_s.fan_sec = 12'h0;
          next_s.fan = s.fan + 16'h1;
        end
      end
    end

    // energy in kWh from Wh pulses
    if (energy_wh_pulse)
    begin
      next_s.wh_cnt = s.wh_cnt + 10'h1;
      if (s.wh_cnt == ucfl_pkg::WH_PER_KWH - 10'h1)
      begin
        next_s.wh_cnt = 10'h0;
        next_s.energy = s.energy + 16'h1;
      end
    end

    // restore from the non-volatile store
    if (nvm_load)
    begin
      next_s.powered = nvm_load_data.powered;
      next_s.enabled = nvm_load_data.enabled;
      next_s.energy = nvm_load_data.energy;
      next_s.fan = nvm_load_data.fan;
    end

    // software clears win over counting
    if (rst_sel == ucfl_pkg::RST_SEL_ENABLED)
    begin
      next_s.enabled = 16'h0;
      next_s.en_sec = 9'h0;
    end
    if (rst_sel == ucfl_pkg::RST_SEL_ENERGY)
    begin
      next_s.energy = 16'h0;
      next_s.wh_cnt = 10'h0;
    end
    if (rst_sel == ucfl_pkg::RST_SEL_FAN)
    begin
      next_s.fan = 16'h0;
      next_s.fan_sec = 12'h0;
    end

    // save on entry into undervoltage
    next_s.uv_prev = dc_undervoltage;
    if (dc_undervoltage && !s.uv_prev)
    begin
      next_s.nvm_stb = 1'b1;
      next_s.nvm.powered = s.powered;
      next_s.nvm.enabled = s.enabled;
      next_s.nvm.energy = s.energy;
      next_s.nvm.fan = s.fan;
    end

    // present alarm and fault
    next_s.alarm = alarm_code_in;
    next_s.fault = fault_active ? fault_code_in : 10'h0;

    // history shift on fault entry only
    next_s.fault_prev = fault_active;
    if (fault_active && !s.fault_prev)
    begin
      for (int i = ucfl_pkg::HIST_DEPTH - 1; i > 0; i--)
        next_s.hist[i] = s.hist[i-1];
      next_s.hist[0].code = fault_code_in;
      // stamp taken as presented; invalid near power-up
      next_s.hist[0].stamp = rtc_now;
      next_s.di_snap = digital_inputs;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.dp <= ucfl_pkg::DP_IDLE;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign nvm_save_stb = s.nvm_stb;
  assign nvm_save_data = s.nvm;
  assign ao_a_value = s.ao_a;
  assign ao_b_value = s.ao_b;
  assign motor_overload_fault = s.ovl_fault;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_fault_entry;
    fault_active && !s.fault_prev;
  endsequence

  sequence s_fault_held;
    fault_active && s.fault_prev;
  endsequence

  sequence s_uv_entry;
    dc_undervoltage && !s.uv_prev;
  endsequence

  property p_ovl_fault;
    @(posedge clk_sys) disable iff (!rst_n)
    (motor_overload_fault == (s.overload == ucfl_pkg::OVL_FULL)) && s.overload <= 7'h64;
  endproperty
  a_ovl_fault: assert property (p_ovl_fault) else $error("overload fault mismatch");

  property p_pulse_cw;
    @(posedge clk_sys) disable iff (!rst_n)
    enc_pulse && enc_dir_cw && s.pulses < ucfl_pkg::PULSE_MAX
    |=> s.pulses == $past(s.pulses) + 16'h1 && s.pulses <= ucfl_pkg::PULSE_MAX;
  endproperty
  a_pulse_cw: assert property (p_pulse_cw) else $error("encoder count step wrong");

  property p_ao_route;
    @(posedge clk_sys) disable iff (!rst_n)
    s.ao_a_src == ucfl_pkg::AO_SRC_PULSES |=> ao_a_value == $past(s.pulses);
  endproperty
  a_ao_route: assert property (p_ao_route) else $error("pulse count not routed");

  property p_nvm_save;
    @(posedge clk_sys) disable iff (!rst_n)
    s_uv_entry |=> nvm_save_stb && nvm_save_data.enabled == $past(s.enabled)
                   && nvm_save_data.powered == $past(s.powered) ##1 !nvm_save_stb;
  endproperty
  a_nvm_save: assert property (p_nvm_save) else $error("counter save missing");

  property p_clr_enabled;
    @(posedge clk_sys) disable iff (!rst_n)
    rst_sel == ucfl_pkg::RST_SEL_ENABLED && !nvm_load |=> s.enabled == 16'h0;
  endproperty
  a_clr_enabled: assert property (p_clr_enabled) else $error("enabled clear lost");

  property p_clr_energy;
    @(posedge clk_sys) disable iff (!rst_n)
    rst_sel == ucfl_pkg::RST_SEL_ENERGY && !nvm_load |=> s.energy == 16'h0 [*2];
  endproperty
  a_clr_energy: assert property (p_clr_energy) else $error("energy clear lost");

  property p_hist_shift;
    @(posedge clk_sys) disable iff (!rst_n)
    s_fault_entry |=> s.hist[1] == $past(s.hist[0]) && s.hist[0].code == $past(fault_code_in)
                      && s.di_snap == $past(digital_inputs);
  endproperty
  a_hist_shift: assert property (p_hist_shift) else $error("history shift wrong");

  property p_hist_once;
    @(posedge clk_sys) disable iff (!rst_n)
    s_fault_held |=> $stable(s.hist);
  endproperty
  a_hist_once: assert property (p_hist_once) else $error("history shifted twice");

  property p_fault_code;
    @(posedge clk_sys) disable iff (!rst_n)
    fault_active |=> s.fault == $past(fault_code_in);
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("active fault code wrong");

endmodule : ucfl_top
`default_nettype wire
